// [inertial_user_gain_offset_trim.sv]
`timescale 1ns/1ns
`default_nettype none
// Operation
// - correction stage runs once per 4250 Hz internal sample period
// - factory coefficients stay internal; only user trims are visible to host
// - gyro x gain trim: 16-bit signed, zero is unity, lsb 2^-15
// - gyro y gain trim acts like x trim on y rate data
// - gyro z gain trim acts like x trim on z rate data
// - accel x gain trim: 16-bit signed, zero is unity, lsb 2^-15
// - accel y gain trim scales y acceleration like x trim
// - accel z gain trim scales z acceleration like x trim
// - gyro x offset low half: lsb equals rate scale over 2^16
// - gyro x offset high half: signed, lsb equals rate scale factor
// - halves join into 32-bit signed offset added to x rate
module inertial_user_gain_offset_trim
  import trim_pkg::*;
(
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // register port
  input  wire reg_req_t    reg_req,
  output var  logic [15:0] reg_rdata,
  output var  logic        reg_rvalid,
  // sample clock select and raw factory-corrected samples
  input  wire logic        use_internal_clk,
  input  wire logic        ext_sample_strobe,
  input  wire sample_t     raw_in [num_axes],
  // trimmed outputs
  output var  sample_t     trim_out_lo [num_axes],
  output var  logic [31:0] gyro_x_out32,
  output var  logic        trim_valid
);

  // ==========================================================================
  // trim registers
  logic [15:0] gain_r [num_axes];
  logic [15:0] gyro_x_offset_trim_lo_r;
  logic [15:0] gyro_x_offset_trim_hi_r;
  // host-visible trims only; factory coefficients live upstream
  // and never reach this register port
  logic        page_hit;
  logic [2:0]  gain_idx;
  logic        gain_hit;
  logic        ofs_lo_hit;
  logic        ofs_hi_hit;
  logic        wr_take;
  logic        rd_take;

  assign page_hit = (reg_req.page == trim_page);

  // ==========================================================================
  // address decode
  always_comb begin
    gain_idx   = 3'h0;
    gain_hit   = 1'b0;
    ofs_lo_hit = 1'b0;
    ofs_hi_hit = 1'b0;
    case (reg_req.addr)
      off_gyro_x_gain: begin
        gain_idx = 3'h0;
        gain_hit = 1'b1;
      end
      off_gyro_y_gain: begin
        gain_idx = 3'h1;
        gain_hit = 1'b1;
      end
      off_gyro_z_gain: begin
        gain_idx = 3'h2;
        gain_hit = 1'b1;
      end
      off_accel_x_gain: begin
        gain_idx = 3'h3;
        gain_hit = 1'b1;
      end
      off_accel_y_gain: begin
        gain_idx = 3'h4;
        gain_hit = 1'b1;
      end
      off_accel_z_gain: begin
        gain_idx = 3'h5;
        gain_hit = 1'b1;
      end
      off_gyro_x_ofs_lo: begin
        ofs_lo_hit = 1'b1;
      end
      off_gyro_x_ofs_hi: begin
        ofs_hi_hit = 1'b1;
      end
      default: begin
        gain_idx   = 3'h0;
        gain_hit   = 1'b0;
        ofs_lo_hit = 1'b0;
        ofs_hi_hit = 1'b0;
      end
    endcase
  end

  // a request only counts on an enabled edge; reads of other pages
  // still answer so the host never waits on a stray address
  assign wr_take = clk_en && reg_req.wr && page_hit;
  assign rd_take = clk_en && reg_req.rd;

  // ==========================================================================
  // trim write
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < num_axes; i++) begin
        gain_r[i] <= trim_reset_val;
      end
    end else if (wr_take && gain_hit) begin
      gain_r[gain_idx] <= reg_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      gyro_x_offset_trim_lo_r <= trim_reset_val;
    end else if (wr_take && ofs_lo_hit) begin
      gyro_x_offset_trim_lo_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      gyro_x_offset_trim_hi_r <= trim_reset_val;
    end else if (wr_take && ofs_hi_hit) begin
      gyro_x_offset_trim_hi_r <= reg_req.wdata;
    end
  end

  // ==========================================================================
  // readback: only user trims; unmapped or other pages read zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_req.rd;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (rd_take) begin
      if (!page_hit) begin
        reg_rdata <= 16'h0000;
      end else if (gain_hit) begin
        reg_rdata <= gain_r[gain_idx];
      end else if (ofs_lo_hit) begin
        reg_rdata <= gyro_x_offset_trim_lo_r;
      end else if (ofs_hi_hit) begin
        reg_rdata <= gyro_x_offset_trim_hi_r;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // ==========================================================================
  // sample tick: internal divider or external strobe
  logic [15:0] tick_cnt_r;
  logic        tick;

  // the divider runs in both modes, so switching to the internal
  // clock costs at most one sample period
  always_comb begin
    if (use_internal_clk) begin
      tick = (tick_cnt_r == 16'(sample_period_cycles - 1));
    end else begin
      tick = ext_sample_strobe;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      if (tick_cnt_r == 16'(sample_period_cycles - 1)) begin
        tick_cnt_r <= 16'h0000;
      end else begin
        tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // correction pipeline
  proc_state_t state_r;
  logic signed [47:0] scaled_r [num_axes];
  logic signed [47:0] scaled_nxt [num_axes];
  logic signed [31:0] gyro_x_offset;

  // high half is the integer part, low half the fraction
  assign gyro_x_offset = $signed({gyro_x_offset_trim_hi_r,
                                  gyro_x_offset_trim_lo_r});

  // y = x * (1 + g/2^15), held with 16 fraction bits so the offset
  // fraction survives until the final truncation
  genvar ax;
  generate
    for (ax = 0; ax < num_axes; ax++) begin : g_axis
      logic signed [33:0] prod;
      assign prod = $signed(raw_in[ax]) * $signed(gain_r[ax]);
      assign scaled_nxt[ax] =
        ($signed(48'(raw_in[ax])) <<< ofs_frac_bits) +
        ($signed(48'(prod)) <<< (ofs_frac_bits - gain_frac_bits));
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= st_idle;
    end else if (clk_en) begin
      // ticks that arrive while busy are dropped, so they must come
      // at least four cycles apart
      case (state_r)
        st_idle: begin
          if (tick) begin
            state_r <= st_scale;
          end
        end
        st_scale: begin
          state_r <= st_bias;
        end
        st_bias: begin
          state_r <= st_done;
        end
        st_done: begin
          state_r <= st_idle;
        end
        default: begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < num_axes; i++) begin
        scaled_r[i] <= 48'sh0;
      end
    end else if (clk_en) begin
      case (state_r)
        st_scale: begin
          for (int i = 0; i < num_axes; i++) begin
            scaled_r[i] <= scaled_nxt[i];
          end
        end
        st_bias: begin
          scaled_r[axis_gyro_x] <= scaled_r[axis_gyro_x] +
                                   48'(gyro_x_offset);
        end
        default: begin
          scaled_r[axis_gyro_x] <= scaled_r[axis_gyro_x];
        end
      endcase
    end
  end

  // ==========================================================================
  // outputs: saturate to 16-bit high word, full 32-bit for gyro x
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    logic signed [31:0] w;
    w = 32'(v >>> ofs_frac_bits);
    if (v >>> ofs_frac_bits > 48'sh7fff) begin
      sat16 = 16'h7fff;
    end else if (v >>> ofs_frac_bits < -48'sh8000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = w[15:0];
    end
  endfunction

  always_ff @(posedge mclk) begin
    if (reset) begin
      trim_valid <= 1'b0;
    end else if (clk_en) begin
      trim_valid <= (state_r == st_done);
    end
  end

  // the 32-bit result keeps the integer part only; the offset
  // fraction reaches it through the carry
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < num_axes; i++) begin
        trim_out_lo[i] <= 16'sh0;
      end
      gyro_x_out32 <= 32'h0;
    end else if (clk_en && state_r == st_done) begin
      for (int i = 0; i < num_axes; i++) begin
        trim_out_lo[i] <= sample_t'(sat16(scaled_r[i]));
      end
      gyro_x_out32 <= scaled_r[axis_gyro_x][47:16];
    end
  end

endmodule // inertial_user_gain_offset_trim
`default_nettype wire

// [trim_pkg.sv]
package trim_pkg;

  // ==========================================================================
  // register map (byte addresses, 16-bit registers, page 0x02)
  localparam logic [7:0] trim_page          = 8'h02;
  localparam logic [7:0] off_gyro_x_gain    = 8'h04;
  localparam logic [7:0] off_gyro_y_gain    = 8'h06;
  localparam logic [7:0] off_gyro_z_gain    = 8'h08;
  localparam logic [7:0] off_accel_x_gain   = 8'h0a;
  localparam logic [7:0] off_accel_y_gain   = 8'h0c;
  localparam logic [7:0] off_accel_z_gain   = 8'h0e;
  localparam logic [7:0] off_gyro_x_ofs_lo  = 8'h10;
  localparam logic [7:0] off_gyro_x_ofs_hi  = 8'h12;
  localparam logic [15:0] trim_reset_val    = 16'h0000;

  // ==========================================================================
  // arithmetic formats
  localparam int gain_frac_bits = 15;
  localparam int ofs_frac_bits  = 16;
  localparam int num_axes       = 6;
  localparam logic [2:0] axis_gyro_x = 3'h0;

  // ==========================================================================
  // timing
  localparam int clk_hz               = 50000000;
  localparam int internal_process_rate = 4250;
  localparam int sample_period_cycles = clk_hz / internal_process_rate;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  page;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef logic signed [15:0] sample_t;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_scale = 2'b01,
    st_bias  = 2'b10,
    st_done  = 2'b11
  } proc_state_t;

endpackage

// [trim_chk.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// trim checker
module trim_chk
  import trim_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // stimulus side
  input wire logic        clk_en,
  input wire reg_req_t    reg_req,
  input wire logic        use_internal_clk,
  input wire logic        ext_sample_strobe,
  // result side
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire sample_t     trim_out_lo [num_axes],
  input wire logic [31:0] gyro_x_out32,
  input wire logic        trim_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (clk_en && reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_rvalid: assert property (clk_en && !reg_req.rd |=> !reg_rvalid)
    else $error("read answer without read");
  a_unmapped_zero: assert property (clk_en && reg_req.rd &&
    reg_req.page != trim_page |=> reg_rdata == 16'h0000)
    else $error("foreign page read not zero");
  a_tick_result: assert property (clk_en && !use_internal_clk &&
    ext_sample_strobe |-> ##[3:4] trim_valid) else $error("tick lost");
  a_valid_pulse: assert property (trim_valid |=> !trim_valid)
    else $error("valid longer than one cycle");
  a_valid_cause: assert property (trim_valid |-> use_internal_clk ||
    $past(ext_sample_strobe, 3) || $past(ext_sample_strobe, 4))
    else $error("valid without tick");
  // results may only move together with the valid pulse
  a_out32_hold: assert property (!trim_valid |-> $stable(gyro_x_out32))
    else $error("offset result moved");
  a_lo_hold: assert property (!trim_valid |-> $stable(trim_out_lo[0]))
    else $error("scaled result moved");
endmodule // trim_chk
bind inertial_user_gain_offset_trim trim_chk chk_u (.mclk, .reset, .clk_en,
  .reg_req, .use_internal_clk, .ext_sample_strobe, .reg_rdata, .reg_rvalid,
  .trim_out_lo, .gyro_x_out32, .trim_valid);
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// trim testbench
module testbench;
  import trim_pkg::*;
  logic        mclk = 0, reset = 1, clk_en = 1, use_internal_clk = 0;
  logic        ext_sample_strobe = 0, reg_rvalid, trim_valid;
  reg_req_t    reg_req = '0;
  sample_t     raw_in [num_axes] = '{default: 16'sh0000};
  sample_t     trim_out_lo [num_axes];
  logic [15:0] reg_rdata, v;
  logic [31:0] gyro_x_out32, ofs = 32'h0000_0000;
  int          n_errors = 0, comparisons = 0, n, g [num_axes];

  always #10 mclk = ~mclk;

  inertial_user_gain_offset_trim dut_u (.mclk, .reset, .clk_en, .reg_req,
    .reg_rdata, .reg_rvalid, .use_internal_clk, .ext_sample_strobe, .raw_in,
    .trim_out_lo, .gyro_x_out32, .trim_valid);

  task automatic summarize;
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle request pulse, released on the edge that takes it
  task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{wr: w, rd: !w, page: p, addr: a, wdata: d};
    @(posedge mclk);
    reg_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] a,
                    input logic [15:0] exp);
    acc(1'b0, p, a, 16'h0000);
    cmp16({15'h0000, reg_rvalid}, 16'h0001);
    cmp16(reg_rdata, exp);
  endtask

  task automatic wait_valid;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (trim_valid !== 1'b1 && n < 12000);
    if (n >= 12000) begin
      n_errors++;
      summarize();
    end
  endtask

  // result = raw * (1 + g / 2^15), plus offset on gyro x only, kept in 2^-16 units
  task automatic check;
    longint f;
    for (int i = 0; i < num_axes; i++) begin
      f = longint'(raw_in[i]) * (32768 + g[i]) * 2;
      if (i == 0) f = f + longint'($signed(ofs));
      f = f >>> 16;
      if (i == 0) cmp32(gyro_x_out32, f[31:0]);
      v = f > 32767 ? 16'h7fff : f < -32768 ? 16'h8000 : f[15:0];
      cmp16(trim_out_lo[i], v);
    end
  endtask

  task automatic tick;
    @(posedge mclk);
    ext_sample_strobe <= 1'b1;
    @(posedge mclk);
    ext_sample_strobe <= 1'b0;
    wait_valid();
    check();
  endtask

  initial begin
    void'($urandom(32'ha7490ea5));
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    for (int k = 0; k < 8; k++) rd(trim_page, 8'(4 + 2 * k), 16'h0000);
    // pass 0 unity, 1 most negative, 2 saturating, then random
    for (int t = 0; t < 5; t++) begin
      for (int k = 0; k < 8; k++) begin
        v = t == 0 ? 16'h0000 : t == 1 ? 16'h8000 : t == 2 ? 16'h7fff
          : 16'($urandom);
        acc(1'b1, trim_page, 8'(4 + 2 * k), v);
        rd(trim_page, 8'(4 + 2 * k), v);
        if (k < 6) g[k] = int'($signed(v));
        else ofs[16 * (k - 6) +: 16] = v;
      end
      @(posedge mclk);
      for (int i = 0; i < num_axes; i++)
        raw_in[i] <= t == 2 ? 16'sh7fff : sample_t'($urandom);
      tick();
    end
    @(posedge mclk);
    clk_en <= 1'b0;
    acc(1'b1, trim_page, 8'h04, 16'h5555);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd(trim_page, 8'h04, 16'(g[0]));
    acc(1'b1, 8'h00, 8'h04, 16'h1234);
    rd(trim_page, 8'h04, 16'(g[0]));
    rd(trim_page, 8'h14, 16'h0000);
    rd(8'h00, 8'h04, 16'h0000);
    @(posedge mclk);
    use_internal_clk <= 1'b1;
    wait_valid();
    wait_valid();
    cmp32(32'(n), 32'(sample_period_cycles));
    check();
    summarize();
  end
endmodule // testbench
`default_nettype wire
